// *** core/bus_idle_wait_control.sv ***
// Purpose: Inter-cycle idle and area 6 wait/burst timing for the external bus
// Assumes: AXI4-Lite register access; cycle requests from same-clock logic
// Notes:   Registers load defaults on aresetn only; manual reset and standby keep them
// Behaviour
// - DMA field idles after acknowledged device cycles
// - DMA field only for single-address DMA
// - Per-area three-bit idle field at 4n
// - Codes decode to 0,1,2,3,6,9,12,15 cycles
// - Read: idle before write or other area
// - DMA write: DMA idle unless same-area same-device DMA write
// - Muxed bus: at least one idle cycle after a processor read
// - Dual-address DMA counts as processor cycle
// - Muxed write then same area: idle wait
// - Zero field means no idle wait before a non-muxed cycle
// - Idle fields reset to fifteen cycles
// - Wait register resets only on power-on
// - Area 6 first wait decoded, ready optional
// - Area 6 burst pitch equals code value
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "bus_idle_wait_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module bus_idle_wait_control
  import bus_idle_wait_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   manual_reset_n,
  input  wire logic                   standby,
  input  wire logic                   cyc_valid,
  input  wire bus_cycle_t             cyc,
  output logic                        cyc_ready,
  input  wire logic                   ext_ready_n,
  output logic                        gap_active,
  output logic                        access_active,
  output logic                        beat_done,
  output logic                        cycle_done
);

  localparam int ACC_MAX = 24;

  // Register file and bus slave state
  logic [31:0]            idle_ctrl, next_idle_ctrl;
  logic [31:0]            wait_ctrl, next_wait_ctrl;
  logic                   aw_held, next_aw_held;
  logic [`AXI_ADDR_W-1:0] aw_addr_q, next_aw_addr;
  logic                   w_held, next_w_held;
  logic [31:0]            w_data_q, next_w_data;
  logic [3:0]             w_strb_q, next_w_strb;
  logic                   next_awready, next_wready, next_arready;
  logic                   next_bvalid, next_rvalid;
  logic [1:0]             next_bresp, next_rresp;
  logic [31:0]            next_rdata;
  logic                   do_write;

  // Sequencer state
  seq_state_t             state, next_state;
  cnt_t                   cnt, next_cnt;
  logic [2:0]             beats, next_beats;
  logic                   honour, next_honour;
  bus_cycle_t             cur, next_cur;
  bus_cycle_t             prev, next_prev;
  logic                   prev_valid, next_prev_valid;
  cnt_t                   last_gap, next_last_gap;
  logic                   next_cyc_ready, next_gap_active, next_access_active;
  logic                   next_beat_done, next_cycle_done;
  logic                   rdy_meta, rdy_sync;
  logic [3:0]             gap_calc;
  logic                   accept;
  cnt_t                   first_wait;
  logic                   first_honour;
  logic [2:0]             pitch_code;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // Read mux; unmapped addresses read as zero
  function automatic logic [31:0] read_mux(input logic [`AXI_ADDR_W-1:0] a,
                                           input logic [31:0] ic, input logic [31:0] wc,
                                           input logic [31:0] st);
    logic [31:0] r;
    r = 32'h0;
    unique case ({a[`AXI_ADDR_W-1:2], 2'h0})
      `IDLE_CTRL_OFFSET: r = ic;
      `WAIT_CTRL_OFFSET: r = wc;
      `STATUS_OFFSET:    r = st;
      default:           r = 32'h0;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [`AXI_ADDR_W-1:0] a);
    logic [`AXI_ADDR_W-1:0] w;
    w = {a[`AXI_ADDR_W-1:2], 2'h0};
    return (w == `IDLE_CTRL_OFFSET) || (w == `WAIT_CTRL_OFFSET) || (w == `STATUS_OFFSET);
  endfunction

  // Ready pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rdy_meta <= ext_ready_n;
      rdy_sync <= rdy_meta;
    end
  end

  // Idle count owed before the offered cycle
  idle_gap_calc u_gap (
    .idle_ctrl  (idle_ctrl),
    .prev_valid (prev_valid),
    .prev       (prev),
    .nxt        (cyc),
    .gap        (gap_calc)
  );

  // Area 6 wait and pitch; other areas carry no waits here
  assign first_wait   = (cyc.area == `AREA6) ?
                        code_cycles(wait_ctrl[`A6_FIRST_WAIT_LSB +: 3]) : 4'h0;
  assign first_honour = (cyc.area == `AREA6) &&
                        (wait_ctrl[`A6_FIRST_WAIT_LSB +: 3] != 3'h0);
  assign pitch_code   = (cur.area == `AREA6) ? wait_ctrl[`A6_BURST_PITCH_LSB +: 3] : 3'h0;
  assign accept       = cyc_valid && cyc_ready;
  assign do_write     = aw_held && w_held && !bvalid;

  // Bus slave next state: address and data taken in either order
  always_comb begin
    next_aw_held   = aw_held;
    next_aw_addr   = aw_addr_q;
    next_w_held    = w_held;
    next_w_data    = w_data_q;
    next_w_strb    = w_strb_q;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_idle_ctrl = idle_ctrl;
    next_wait_ctrl = wait_ctrl;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      if ({aw_addr_q[`AXI_ADDR_W-1:2], 2'h0} == `IDLE_CTRL_OFFSET) begin
        next_idle_ctrl = merge(idle_ctrl, w_data_q, w_strb_q, `IDLE_CTRL_MASK);
      end
      if ({aw_addr_q[`AXI_ADDR_W-1:2], 2'h0} == `WAIT_CTRL_OFFSET) begin
        next_wait_ctrl = merge(wait_ctrl, w_data_q, w_strb_q, `WAIT_CTRL_MASK);
      end
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = read_mux(araddr, idle_ctrl, wait_ctrl,
                             {18'h0, rdy_sync, prev_valid, last_gap, cnt, 2'h0, state});
      next_rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Bus slave registers; only power-on reset touches the control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ctrl <= `IDLE_CTRL_RESET;
      wait_ctrl <= `WAIT_CTRL_RESET;
      aw_held   <= 1'b0;
      aw_addr_q <= 12'h0;
      w_held    <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      arready   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0;
      rresp     <= `RESP_OKAY;
    end else begin
      idle_ctrl <= next_idle_ctrl;
      wait_ctrl <= next_wait_ctrl;
      aw_held   <= next_aw_held;
      aw_addr_q <= next_aw_addr;
      w_held    <= next_w_held;
      w_data_q  <= next_w_data;
      w_strb_q  <= next_w_strb;
      awready   <= next_awready;
      wready    <= next_wready;
      arready   <= next_arready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
    end
  end

  // Sequencer: idle gap, first access with waits, then burst beats
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_beats      = beats;
    next_honour     = honour;
    next_cur        = cur;
    next_prev       = prev;
    next_prev_valid = prev_valid;
    next_last_gap   = last_gap;
    next_beat_done  = 1'b0;
    next_cycle_done = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_cur      = cyc;
          next_beats    = cyc.burst_beats;
          next_last_gap = gap_calc;
          next_honour   = first_honour;
          if (gap_calc != 4'h0) begin
            next_state = ST_GAP;
            next_cnt   = gap_calc;
          end else begin
            next_state = ST_ACCESS;
            next_cnt   = first_wait;
          end
        end
      end
      ST_GAP: begin
        if (cnt == 4'h1) begin
          next_state  = ST_ACCESS;
          next_cnt    = (cur.area == `AREA6) ?
                        code_cycles(wait_ctrl[`A6_FIRST_WAIT_LSB +: 3]) : 4'h0;
          next_honour = (cur.area == `AREA6) && (wait_ctrl[`A6_FIRST_WAIT_LSB +: 3] != 3'h0);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ST_ACCESS, ST_BURST: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (honour && rdy_sync) begin
          next_cnt = 4'h0;
        end else begin
          next_beat_done = 1'b1;
          if (beats != 3'h0) begin
            next_state  = ST_BURST;
            next_beats  = beats - 3'h1;
            next_cnt    = {1'b0, pitch_code};
            next_honour = (pitch_code != 3'h0);
          end else begin
            next_state      = ST_IDLE;
            next_cycle_done = 1'b1;
            next_prev       = cur;
            next_prev_valid = 1'b1;
          end
        end
      end
    endcase
    if (!manual_reset_n) begin
      next_state      = ST_IDLE;
      next_cnt        = 4'h0;
      next_prev_valid = 1'b0;
      next_beat_done  = 1'b0;
      next_cycle_done = 1'b0;
    end
    next_cyc_ready     = (next_state == ST_IDLE) && !standby && manual_reset_n;
    next_gap_active    = (next_state == ST_GAP);
    next_access_active = (next_state == ST_ACCESS) || (next_state == ST_BURST);
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= ST_IDLE;
      cnt           <= 4'h0;
      beats         <= 3'h0;
      honour        <= 1'b0;
      cur           <= '0;
      prev          <= '0;
      prev_valid    <= 1'b0;
      last_gap      <= 4'h0;
      cyc_ready     <= 1'b0;
      gap_active    <= 1'b0;
      access_active <= 1'b0;
      beat_done     <= 1'b0;
      cycle_done    <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      beats         <= next_beats;
      honour        <= next_honour;
      cur           <= next_cur;
      prev          <= next_prev;
      prev_valid    <= next_prev_valid;
      last_gap      <= next_last_gap;
      cyc_ready     <= next_cyc_ready;
      gap_active    <= next_gap_active;
      access_active <= next_access_active;
      beat_done     <= next_beat_done;
      cycle_done    <= next_cycle_done;
    end
  end

  // Checks on reset, gaps and access timing
  idle_reset_a: assert property (@(posedge aclk) !aresetn |=> idle_ctrl == 32'h77777777)
    else $error("idle control reset value wrong");
  manual_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual_reset_n && !do_write) |=> ($stable(idle_ctrl) && $stable(wait_ctrl)))
    else $error("manual reset altered control registers");
  gap_enter_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && gap_calc != 4'h0) |=> (gap_active && cnt == $past(gap_calc)))
    else $error("idle gap not started with computed length");
  gap_len_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && gap_calc == 4'h3) |=> gap_active [*3] ##1 access_active)
    else $error("three-cycle gap has wrong length");
  nogap_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && gap_calc == 4'h0) |=> (access_active && !gap_active))
    else $error("zero gap still inserted idle");
  mpx_min_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && cyc.muxed_addr_data_bus && prev_valid && !prev.write && !prev.dma_single) |=> gap_active)
    else $error("muxed access after read lacks idle cycle");
  dual_dma_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && prev_valid && !prev.dma_single && prev.write && cyc.area == prev.area
     && !cyc.muxed_addr_data_bus && !cyc.sdram_pipe_idle) |=> !gap_active)
    else $error("same-area cycle after write got an idle gap");
  dma_write_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && prev_valid && prev.dma_single && prev.write && !cyc.write
     && idle_ctrl[`DMA_IDLE_LSB +: 3] == 3'h2) |=> (gap_active && cnt == 4'h2))
    else $error("DMA field gap missing after device write");
  ready_ext_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (access_active && cnt == 4'h0 && honour && rdy_sync) |=> (access_active && !beat_done))
    else $error("access ended while ready pin said not ready");
  first_wait_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && gap_calc == 4'h0 && cyc.area == `AREA6
     && wait_ctrl[`A6_FIRST_WAIT_LSB +: 3] == 3'h4) |=> cnt == 4'h6)
    else $error("area 6 first wait code 4 not six cycles");
  pitch_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (access_active && cnt == 4'h0 && !(honour && rdy_sync) && beats != 3'h0)
    |=> (state == ST_BURST && cnt == {1'b0, $past(pitch_code)}))
    else $error("burst pitch not loaded from code");
  done_bound_a: assert property (@(posedge aclk) disable iff (!aresetn || !manual_reset_n)
    (accept && !first_honour && cyc.burst_beats == 3'h0) |-> ##[1:ACC_MAX] cycle_done)
    else $error("single access did not finish in time");

  gap_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) accept ##1 gap_active [*4]);
  burst_c:    cover property (@(posedge aclk) disable iff (!aresetn) state == ST_BURST ##1 beat_done);
  ext_c:      cover property (@(posedge aclk) disable iff (!aresetn) honour && rdy_sync && cnt == 4'h0);
  wr_c:       cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);

endmodule
`default_nettype wire

// *** core/idle_gap_calc.sv ***
// Purpose: Idle cycles owed between the previous and the next external cycle
// Assumes: Purely combinational, fed from registered state
// Notes:   Dual-address DMA arrives with dma_single low and is handled like a processor cycle
`include "bus_idle_wait_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module idle_gap_calc
  import bus_idle_wait_pkg::*;
(
  input  wire logic [31:0] idle_ctrl,
  input  wire logic        prev_valid,
  input  wire bus_cycle_t  prev,
  input  wire bus_cycle_t  nxt,
  output logic [3:0]       gap
);

  logic       same_area;
  logic       same_dev;
  logic [2:0] area_code;
  cnt_t       m_cycles;
  cnt_t       d_cycles;

  // Field of the area being left, and the DMA device field
  assign same_area = (prev.area == nxt.area);
  assign same_dev  = (prev.dma_dev == nxt.dma_dev);
  assign area_code = (prev.area == `AREA_NONE) ? 3'h0 :
                     idle_ctrl[{prev.area, 2'h0} +: 3];
  assign m_cycles  = code_cycles(area_code);
  assign d_cycles  = code_cycles(idle_ctrl[`DMA_IDLE_LSB +: 3]);

  // Choose the idle count from the preceding and following cycle kinds
  always_comb begin
    gap = 4'h0;
    if (prev_valid) begin
      if (prev.dma_single && prev.write) begin
        // Device to memory: DMA field before anything but same-area, same-device DMA write
        if (!(nxt.dma_single && nxt.write && same_area && same_dev)) begin
          gap = d_cycles;
        end
        if (nxt.muxed_addr_data_bus && !same_area && (gap == 4'h0)) begin
          gap = 4'h1;
        end
      end else if (!prev.write) begin
        // Read, single DMA read or dual DMA read: area field as for a processor read; after a single DMA read only, DMA field before same-device DMA write
        if (!same_area || nxt.write) begin
          gap = m_cycles;
        end
        if (prev.dma_single && nxt.dma_single && nxt.write && same_dev) begin
          gap = d_cycles;
        end
        if (nxt.muxed_addr_data_bus && (!prev.dma_single || !same_area) && (gap == 4'h0)) begin
          gap = 4'h1;
        end
      end else begin
        // Write: area field only on leaving the area, or same-area muxed/SDRAM cases
        if (!same_area) begin
          gap = m_cycles;
        end else if (nxt.muxed_addr_data_bus || nxt.sdram_pipe_idle) begin
          gap = m_cycles;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** include/bus_idle_wait_defines.svh ***
// Purpose: Offsets, field positions, reset values and cycle counts of the idle/wait controller
// Assumes: Included by the package and by every design file
// Notes:   Definitions only
`ifndef BUS_IDLE_WAIT_DEFINES_SVH
`define BUS_IDLE_WAIT_DEFINES_SVH

// Register byte addresses on the control bus
`define AXI_ADDR_W          12
`define IDLE_CTRL_OFFSET    12'h000
`define WAIT_CTRL_OFFSET    12'h004
`define STATUS_OFFSET       12'h008

// Reset values and writable-bit masks
`define IDLE_CTRL_RESET     32'h77777777
`define IDLE_CTRL_MASK      32'h77777777
`define WAIT_CTRL_RESET     32'hfffeefff
`define WAIT_CTRL_MASK      32'hfffeefff

// Field positions
`define DMA_IDLE_LSB        28
`define A6_FIRST_WAIT_LSB   29
`define A6_BURST_PITCH_LSB  26
`define AREA6               3'h6
`define AREA_NONE           3'h7

// Cycle counts for the upper half of the three-bit idle/wait code
`define CODE4_CYCLES        4'h6
`define CODE5_CYCLES        4'h9
`define CODE6_CYCLES        4'hc
`define CODE7_CYCLES        4'hf

// Bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** include/bus_idle_wait_pkg.sv ***
// Purpose: Types and the shared code decoder of the idle/wait controller
// Assumes: bus_idle_wait_defines.svh on the include path
// Notes:   Numbers live in the header, types live here
`include "bus_idle_wait_defines.svh"
package bus_idle_wait_pkg;

  typedef logic [3:0] cnt_t;

  // One external bus cycle as offered by the bus sequencer
  typedef struct packed {
    logic [2:0] area;            // External area 0..6
    logic       write;           // High for write; for single DMA, write means device to memory
    logic       dma_single;      // Single-address DMA; dual-address DMA comes in as zero
    logic [1:0] dma_dev;         // Which acknowledged device (dma_ack_strobe channel)
    logic       muxed_addr_data_bus;             // Area uses muxed_addr_data_bus
    logic       sdram_pipe_idle; // SDRAM pipeline asks for a same-area idle
    logic [2:0] burst_beats;     // Data accesses after the first
  } bus_cycle_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_GAP    = 2'h1,
    ST_ACCESS = 2'h3,
    ST_BURST  = 2'h2
  } seq_state_t;

  // Three-bit code to cycles: 0,1,2,3,6,9,12,15
  function automatic cnt_t code_cycles(input logic [2:0] code);
    cnt_t r;
    r = {1'b0, code};
    unique case (code)
      3'h4: r = `CODE4_CYCLES;
      3'h5: r = `CODE5_CYCLES;
      3'h6: r = `CODE6_CYCLES;
      3'h7: r = `CODE7_CYCLES;
      default: r = {1'b0, code};
    endcase
    return r;
  endfunction

endpackage

// *** testbench/ext_mem_model.sv ***
// Purpose: External memory ready model
// Assumes: Same clock as the controller
// Notes:   Not-ready for stall cycles per access
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input  wire logic       aclk,
  input  wire logic       access_active,
  input  wire logic [3:0] stall,
  output logic            ext_ready_n
);
  logic [3:0] left = 4'h0;
  logic       was  = 1'b0;
  // Load stall count as an access starts
  always_ff @(posedge aclk) begin
    was <= access_active;
    if (access_active && !was) begin
      left <= stall;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign ext_ready_n = (left != 4'h0);
endmodule
`default_nettype wire

// *** testbench/tb_bus_idle_wait_control.sv ***
// Purpose: Self-checking bench
// Assumes: ext_mem_model drives ready
// Notes:   Integer model of gaps and lengths
`timescale 1ns/10ps
`default_nettype none
module tb_bus_idle_wait_control import bus_idle_wait_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid;
  logic        rready, manual_reset_n, standby, cyc_valid;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cyc_ready, ext_ready_n, gap_active;
  logic        access_active, beat_done, cycle_done;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q, v;
  logic [3:0]  wstrb, stall;
  logic [1:0]  bresp, rresp, r;
  bus_cycle_t  cyc;
  int          failures, tests_run, g, a, b, k, x;

  always #10 aclk = ~aclk;
  bus_idle_wait_control dut_u (.*);
  ext_mem_model mem_u (.*);

  // Cycles of a three-bit code
  function automatic int dec(int c);
    return c < 4 ? c : 3 * c - 6;
  endfunction
  function automatic bus_cycle_t mk(int ar, bit w, bit ds, bit m, int nb);
    bus_cycle_t c;
    c = '0;
    c.area = ar[2:0];
    c.write = w;
    c.dma_single = ds;
    c.muxed_addr_data_bus = m;
    c.burst_beats = nb[2:0];
    return c;
  endfunction
  function automatic int rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One register access, held until each channel is taken
  task automatic axi(bit w, logic [11:0] ad, logic [31:0] d);
    int n;
    bit pa, pw;
    n = 0;
    pa = 1;
    pw = w;
    @(posedge aclk);
    if (w) begin
      {awaddr, wdata} <= {ad, d};
      {awvalid, wvalid, bready} <= 3'h7;
    end else begin
      araddr <= ad;
      {arvalid, rready} <= 2'h3;
    end
    while ((pa || pw) && n < 99) begin
      @(posedge aclk);
      n++;
      if (pa && (w ? awready : arready) === 1'b1) begin
        pa = 0;
        {awvalid, arvalid} <= 2'h0;
      end
      if (pw && wready === 1'b1) begin
        pw = 0;
        wvalid <= 1'b0;
      end
    end
    while ((w ? bvalid : rvalid) !== 1'b1 && n < 99) begin
      @(posedge aclk);
      n++;
    end
    q = rdata;
    r = w ? bresp : rresp;
    {bready, rready} <= 2'h0;
    if (n >= 99) begin
      failures++;
      test_done();
    end
  endtask
  // One bus cycle; counts gap and access cycles
  task automatic run(bus_cycle_t c);
    int n;
    n = 0;
    @(posedge aclk);
    cyc <= c;
    cyc_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (cyc_ready !== 1'b1 && n < 99);
    cyc_valid <= 1'b0;
    g = 0;
    a = 0;
    b = 0;
    do begin
      @(posedge aclk);
      n++;
      g += int'(gap_active === 1'b1);
      b += int'(beat_done === 1'b1);
      a += int'(access_active === 1'b1);
    end while (cycle_done !== 1'b1 && n < 400);
    if (n >= 400) begin
      failures++;
      test_done();
    end
  endtask

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid} = '0;
    {rready, standby, cyc_valid, manual_reset_n} = 4'h1;
    {awaddr, araddr, wdata, cyc, stall} = '0;
    wstrb = 4'hf;
    {failures, tests_run, x} = {32'd0, 32'd0, 32'd57};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi(0, 12'h000, 0);
    chk("idle rst", 32'h77777777, q);
    axi(0, 12'h004, 0);
    chk("wait rst", 32'hfffeefff, q);
    axi(0, 12'h00c, 0);
    chk("unmapped", 32'h2, {30'h0, r});
    chk("unmapped rd", 32'h0, q);
    axi(1, 12'h00c, 0);
    chk("unmapped wr", 32'h2, {30'h0, r});
    v = rnd();
    axi(1, 12'h000, v);
    chk("wr resp", 32'h0, {30'h0, r});
    axi(0, 12'h000, 0);
    chk("idle rw", v & 32'h77777777, q);
    v = rnd();
    axi(1, 12'h004, v);
    {manual_reset_n, standby} <= 2'h1;
    @(posedge aclk);
    {manual_reset_n, standby} <= 2'h2;
    axi(0, 12'h004, 0);
    chk("wait kept", v & 32'hfffeefff, q);
    $display("registers done");
    // Area 1 and DMA fields across all codes
    for (k = 0; k < 8; k++) begin
      axi(1, 12'h000, 32'((k << 4) | ((7 - k) << 28)));
      run(mk(1, 0, 0, 0, 0));
      run(mk(2, 0, 0, 0, 0));
      chk("area chg", dec(k), g);
      run(mk(1, 0, 0, 0, 0));
      chk("zero fld", 0, g);
      run(mk(1, 1, 0, 0, 0));
      chk("rd to wr", dec(k), g);
      run(mk(1, 0, 0, 0, 0));
      chk("wr to rd", 0, g);
      run(mk(1, 1, 1, 0, 0));
      chk("rd to dma", dec(k), g);
      run(mk(1, 0, 0, 0, 0));
      chk("dma wr", dec(7 - k), g);
      axi(0, 12'h008, 0);
      chk("status", 32'h1000 | (dec(7 - k) << 8), q);
      run(mk(1, 1, 0, 1, 0));
      run(mk(1, 0, 0, 1, 0));
      chk("mpx wr", dec(k), g);
      run(mk(1, 0, 0, 1, 0));
      chk("mpx rd", 1, g);
    end
    $display("gaps done");
    axi(1, 12'h000, 0);
    for (k = 0; k < 8; k++) begin
      axi(1, 12'h004, 32'((k << 29) | ((7 - k) << 26)));
      run(mk(6, 0, 0, 0, 2));
      chk("a6 len", dec(k) + 1 + 2 * (8 - k), a);
      chk("a6 beats", 3, b);
    end
    stall <= 4'h8;
    axi(1, 12'h004, 32'h80000000);
    run(mk(6, 0, 0, 0, 0));
    chk("stretch", 1, a > 7);
    axi(1, 12'h004, 0);
    run(mk(6, 0, 0, 0, 3));
    chk("ready ignored", 4, a);
    $display("area6 done");
    test_done();
  end
endmodule
`default_nettype wire
